// >>> attenuator.sv
// Applies an attenuation of 1 dB per unit to one signed sample.
// Assumes the caller registers the result; this module is combinational.
`timescale 1ns/1ns
module attenuator #(
    parameter int SAMPLE_WIDTH = 16
) (
    input wire logic signed [SAMPLE_WIDTH-1:0] sample_i, // Input sample
    input wire logic [7:0] atten_i, // Attenuation in 1 dB units
    output logic signed [SAMPLE_WIDTH-1:0] sample_o // Attenuated sample
);

    // --------------------------------------------------------------
    // Gain lookup
    // --------------------------------------------------------------
    // Gain for the step within one 6 dB octave, in Q1.15.
    function automatic logic [15:0] mantissa(input logic [2:0] step);
        case (step)
            3'h0: mantissa = 16'h7fff;
            3'h1: mantissa = 16'h7215;
            3'h2: mantissa = 16'h65ad;
            3'h3: mantissa = 16'h5a9e;
            3'h4: mantissa = 16'h50c3;
            default: mantissa = 16'h47fb;
        endcase
    endfunction

    logic [7:0] octave;
    logic [2:0] step;
    logic signed [SAMPLE_WIDTH+16:0] product;

    always_comb begin
        octave = atten_i / 8'(audio_regs_pkg::STEPS_PER_HALVING);
        step = 3'(atten_i % 8'(audio_regs_pkg::STEPS_PER_HALVING));
        product = sample_i * $signed({1'b0, mantissa(step)});
        product = product >>> audio_regs_pkg::MANTISSA_FRAC_BITS;
        // Large values keep shifting the level down and end at silence.
        if (octave >= 8'(SAMPLE_WIDTH)) begin
            sample_o = '0;
        end else begin
            sample_o = SAMPLE_WIDTH'(product >>> octave);
        end
    end

endmodule // attenuator

// >>> audio_regs_pkg.sv
// Package for the right-channel volume, mix and 44.1 kHz PLL register bank.
// Assumes one 250 MHz clock domain and an 8-bit register address space.
package audio_regs_pkg;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_RIGHT_ATTENUATION = 8'h48;
    localparam logic [7:0] ADDR_RIGHT_TO_LEFT_MIX = 8'h49;
    localparam logic [7:0] ADDR_PLL_OUT_DIV_44K1 = 8'h50;
    localparam logic [7:0] ADDR_PLL_FRACTION_44K1_LOW = 8'h51;
    localparam logic [7:0] ADDR_PLL_FRACTION_44K1_HIGH = 8'h52;

    // --------------------------------------------------------------
    // Reset values and fields
    // --------------------------------------------------------------
    localparam logic [7:0] RESET_RIGHT_ATTENUATION = 8'h00;
    localparam logic [7:0] RESET_RIGHT_TO_LEFT_MIX = 8'hff;
    localparam logic [4:0] RESET_PLL_OUT_DIV_44K1 = 5'h00;
    localparam logic [7:0] RESET_PLL_FRACTION_BYTE = 8'h00;
    localparam int DIVIDER_WIDTH = 5;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // --------------------------------------------------------------
    // Attenuation arithmetic
    // --------------------------------------------------------------
    localparam int STEPS_PER_HALVING = 6;
    localparam int MANTISSA_FRAC_BITS = 15;

    // One register access taken from the control bus.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // One output sample pair.
    typedef struct packed {
        logic signed [15:0] right;
        logic signed [15:0] mix;
    } sample_pair_type;

endpackage

// >>> regs_host_model.sv
// Host controller model issuing accesses on the register port.
// Assumes the bench calls its tasks; requests change at falling edges.
`timescale 1ns/1ns
module regs_host_model (
    input wire logic clk_sys_i, // System clock
    input wire logic [7:0] rdata_i, // Read data
    input wire logic rvalid_i, // Read data valid
    output audio_regs_pkg::reg_req_type req_o // Register access
);
    initial begin
        req_o = '0;
    end

    // Each request stands over exactly one rising edge.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        req_o = {1'b1, 1'b0, a, d};
        @(negedge clk_sys_i);
        req_o = '0;
    endtask

    task automatic read(input logic [7:0] a, output logic [8:0] vd);
        @(negedge clk_sys_i);
        req_o = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys_i);
        req_o = '0;
        vd = {rvalid_i, rdata_i};
    endtask
endmodule // regs_host_model

// >>> regs_props.sv
// Checker for the right volume, mix and 44.1 kHz PLL register bank.
// Assumes it is bound to the bank top module and sees only its ports.
`timescale 1ns/1ns
module regs_props (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic soft_reset_i, // Software reset
    input wire audio_regs_pkg::reg_req_type reg_req_i, // Access
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic reg_rvalid_o, // Read valid
    input wire logic sample_valid_i, // Strobe in
    input wire logic signed [15:0] right_sample_i, // Sample in
    input wire audio_regs_pkg::sample_pair_type sample_o, // Samples out
    input wire logic sample_valid_o, // Strobe out
    input wire logic [7:0] right_attenuation_o, // Right gain in use
    input wire logic [7:0] right_to_left_mix_o, // Mix gain in use
    input wire logic [5:0] pll_div_ratio_44k1_o, // Division ratio
    input wire logic [15:0] pll_fraction_44k1_o // PLL fraction
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_wr(a);
        reg_req_i.wr && !soft_reset_i && reg_req_i.addr == a;
    endsequence

    a_read_answer: assert property (
        reg_req_i.rd && !soft_reset_i |=> reg_rvalid_o)
        else $error("read gave no valid pulse");
    a_read_quiet: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
        else $error("valid pulse without read");
    a_strobe_out: assert property (sample_valid_i |=> sample_valid_o)
        else $error("output strobe missing");
    a_strobe_quiet: assert property (
        !sample_valid_i |=> !sample_valid_o)
        else $error("output strobe without input strobe");
    a_gain_hold: assert property (!sample_valid_i |=>
        $stable(right_attenuation_o) && $stable(right_to_left_mix_o))
        else $error("gain changed between strobes");
    a_div_ratio: assert property (s_wr(8'h50) |=>
        pll_div_ratio_44k1_o == $past(reg_req_i.wdata[4:0]) + 6'd1)
        else $error("division ratio wrong");
    a_frac_low: assert property (s_wr(8'h51) |=>
        pll_fraction_44k1_o[7:0] == $past(reg_req_i.wdata))
        else $error("fraction low byte wrong");
    a_frac_high: assert property (s_wr(8'h52) |=>
        pll_fraction_44k1_o[15:8] == $past(reg_req_i.wdata))
        else $error("fraction high byte wrong");
    a_soft_clear: assert property (soft_reset_i |=>
        pll_div_ratio_44k1_o == 6'd1 && pll_fraction_44k1_o == 16'h0000)
        else $error("soft reset left pll values");
    a_max_silent: assert property (
        sample_valid_o && right_attenuation_o == 8'hff |-> sample_o.right == 0)
        else $error("full attenuation not silent");
    a_mix_silent: assert property (
        sample_valid_o && right_to_left_mix_o == 8'hff |-> sample_o.mix == 0)
        else $error("full mix attenuation not silent");
    a_unmapped_zero: assert property (reg_req_i.rd && !soft_reset_i &&
        !(reg_req_i.addr inside {[8'h48:8'h49], [8'h50:8'h52]})
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule // regs_props

bind right_volume_mix_pll441_regs regs_props i_regs_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .sample_valid_i(sample_valid_i),
    .right_sample_i(right_sample_i), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o),
    .right_attenuation_o(right_attenuation_o),
    .right_to_left_mix_o(right_to_left_mix_o),
    .pll_div_ratio_44k1_o(pll_div_ratio_44k1_o),
    .pll_fraction_44k1_o(pll_fraction_44k1_o));

// >>> right_volume_mix_pll441_regs.sv
// Register bank for right-channel attenuation, right-to-left mix and the
// 44.1 kHz PLL divider and fraction, with the right-channel gain path.
// Assumes register accesses arrive already decoded from the control bus.
//
// How it works
// - Right output sample is scaled by the right attenuation register.
// - Each unit of an attenuation value adds one 1 dB step.
// - All ones in right attenuation gives the largest attenuation.
// - Right attenuation is read/write and resets to zero on both resets.
// - Mix register attenuates the right channel's contribution to left.
// - Mix register is read/write and resets to all ones on both resets.
// - Divider register holds five low bits; upper three are ignored.
// - For 44.1 kHz the oscillator divides by divider value plus one.
// - Fraction low register gives bits 7..0, high gives bits 15..8.
// - Divider and fraction registers read/write, clear on both resets.
`timescale 1ns/1ns
module right_volume_mix_pll441_regs #(
    parameter int SAMPLE_WIDTH = 16
) (
    input wire logic clk_sys_i, // 250 MHz system clock
    input wire logic rst_n_i, // Synchronous hardware reset, active low
    input wire logic soft_reset_i, // Software reset, one-cycle pulse
    input wire audio_regs_pkg::reg_req_type reg_req_i, // Register access
    output logic [7:0] reg_rdata_o, // Read data
    output logic reg_rvalid_o, // Read data valid, one-cycle pulse
    input wire logic sample_valid_i, // Sample boundary strobe
    input wire logic signed [15:0] right_sample_i, // Right channel sample
    output audio_regs_pkg::sample_pair_type sample_o, // Right and mix out
    output logic sample_valid_o, // Output sample valid pulse
    output logic [7:0] right_attenuation_o, // Gain in use on right path
    output logic [7:0] right_to_left_mix_o, // Gain in use on mix path
    output logic [5:0] pll_div_ratio_44k1_o, // Oscillator division ratio
    output logic [15:0] pll_fraction_44k1_o // 16-bit PLL fraction
);

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    logic [7:0] right_attenuation;
    logic [7:0] right_to_left_mix;
    logic [4:0] pll_out_div_44k1;
    logic [7:0] pll_fraction_44k1_low;
    logic [7:0] pll_fraction_44k1_high;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [7:0] next_right_attenuation;
    logic [7:0] next_right_to_left_mix;
    logic [4:0] next_pll_out_div_44k1;
    logic [7:0] next_pll_fraction_44k1_low;
    logic [7:0] next_pll_fraction_44k1_high;
    logic [7:0] next_reg_rdata;
    logic next_reg_rvalid;

    always_comb begin
        next_right_attenuation = right_attenuation;
        next_right_to_left_mix = right_to_left_mix;
        next_pll_out_div_44k1 = pll_out_div_44k1;
        next_pll_fraction_44k1_low = pll_fraction_44k1_low;
        next_pll_fraction_44k1_high = pll_fraction_44k1_high;
        next_reg_rvalid = reg_req_i.rd;
        next_reg_rdata = reg_rdata;
        if (soft_reset_i) begin
            next_right_attenuation =
                audio_regs_pkg::RESET_RIGHT_ATTENUATION;
            next_right_to_left_mix =
                audio_regs_pkg::RESET_RIGHT_TO_LEFT_MIX;
            next_pll_out_div_44k1 =
                audio_regs_pkg::RESET_PLL_OUT_DIV_44K1;
            next_pll_fraction_44k1_low =
                audio_regs_pkg::RESET_PLL_FRACTION_BYTE;
            next_pll_fraction_44k1_high =
                audio_regs_pkg::RESET_PLL_FRACTION_BYTE;
            next_reg_rvalid = 1'b0;
        end else if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                audio_regs_pkg::ADDR_RIGHT_ATTENUATION: begin
                    next_right_attenuation = reg_req_i.wdata;
                end
                audio_regs_pkg::ADDR_RIGHT_TO_LEFT_MIX: begin
                    next_right_to_left_mix = reg_req_i.wdata;
                end
                audio_regs_pkg::ADDR_PLL_OUT_DIV_44K1: begin
                    next_pll_out_div_44k1 =
                        reg_req_i.wdata[audio_regs_pkg::DIVIDER_WIDTH-1:0];
                end
                audio_regs_pkg::ADDR_PLL_FRACTION_44K1_LOW: begin
                    next_pll_fraction_44k1_low = reg_req_i.wdata;
                end
                audio_regs_pkg::ADDR_PLL_FRACTION_44K1_HIGH: begin
                    next_pll_fraction_44k1_high = reg_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
        if (reg_req_i.rd && !soft_reset_i) begin
            case (reg_req_i.addr)
                audio_regs_pkg::ADDR_RIGHT_ATTENUATION: begin
                    next_reg_rdata = right_attenuation;
                end
                audio_regs_pkg::ADDR_RIGHT_TO_LEFT_MIX: begin
                    next_reg_rdata = right_to_left_mix;
                end
                audio_regs_pkg::ADDR_PLL_OUT_DIV_44K1: begin
                    next_reg_rdata = {3'h0, pll_out_div_44k1};
                end
                audio_regs_pkg::ADDR_PLL_FRACTION_44K1_LOW: begin
                    next_reg_rdata = pll_fraction_44k1_low;
                end
                audio_regs_pkg::ADDR_PLL_FRACTION_44K1_HIGH: begin
                    next_reg_rdata = pll_fraction_44k1_high;
                end
                default: begin
                    next_reg_rdata = audio_regs_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            right_attenuation <= audio_regs_pkg::RESET_RIGHT_ATTENUATION;
            right_to_left_mix <= audio_regs_pkg::RESET_RIGHT_TO_LEFT_MIX;
            pll_out_div_44k1 <= audio_regs_pkg::RESET_PLL_OUT_DIV_44K1;
            pll_fraction_44k1_low <= audio_regs_pkg::RESET_PLL_FRACTION_BYTE;
            pll_fraction_44k1_high <= audio_regs_pkg::RESET_PLL_FRACTION_BYTE;
            reg_rdata <= audio_regs_pkg::READ_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            right_attenuation <= next_right_attenuation;
            right_to_left_mix <= next_right_to_left_mix;
            pll_out_div_44k1 <= next_pll_out_div_44k1;
            pll_fraction_44k1_low <= next_pll_fraction_44k1_low;
            pll_fraction_44k1_high <= next_pll_fraction_44k1_high;
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    assign reg_rdata_o = reg_rdata;
    assign reg_rvalid_o = reg_rvalid;

    // --------------------------------------------------------------
    // PLL settings
    // --------------------------------------------------------------
    logic [5:0] pll_div_ratio;
    logic [15:0] pll_fraction;
    logic [5:0] next_pll_div_ratio;
    logic [15:0] next_pll_fraction;

    always_comb begin
        next_pll_div_ratio = {1'b0, next_pll_out_div_44k1} + 6'h01;
        next_pll_fraction = {next_pll_fraction_44k1_high,
                             next_pll_fraction_44k1_low};
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pll_div_ratio <= {1'b0, audio_regs_pkg::RESET_PLL_OUT_DIV_44K1}
                             + 6'h01;
            pll_fraction <= {audio_regs_pkg::RESET_PLL_FRACTION_BYTE,
                             audio_regs_pkg::RESET_PLL_FRACTION_BYTE};
        end else begin
            pll_div_ratio <= next_pll_div_ratio;
            pll_fraction <= next_pll_fraction;
        end
    end

    assign pll_div_ratio_44k1_o = pll_div_ratio;
    assign pll_fraction_44k1_o = pll_fraction;

    // --------------------------------------------------------------
    // Gain path
    // --------------------------------------------------------------
    // Gains are captured only on a sample strobe, so a word never sees a
    // gain that changes while it is being computed.
    logic [7:0] active_right_gain;
    logic [7:0] active_mix_gain;
    logic [7:0] next_active_right_gain;
    logic [7:0] next_active_mix_gain;
    audio_regs_pkg::sample_pair_type sample_out;
    audio_regs_pkg::sample_pair_type next_sample_out;
    logic sample_valid;
    logic next_sample_valid;
    logic signed [15:0] right_scaled;
    logic signed [15:0] mix_scaled;

    attenuator #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) right_path (
        .sample_i(right_sample_i),
        .atten_i(right_attenuation),
        .sample_o(right_scaled)
    );

    attenuator #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) mix_path (
        .sample_i(right_sample_i),
        .atten_i(right_to_left_mix),
        .sample_o(mix_scaled)
    );

    always_comb begin
        next_active_right_gain = active_right_gain;
        next_active_mix_gain = active_mix_gain;
        next_sample_out = sample_out;
        next_sample_valid = sample_valid_i;
        if (sample_valid_i) begin
            next_active_right_gain = right_attenuation;
            next_active_mix_gain = right_to_left_mix;
            next_sample_out.right = right_scaled;
            next_sample_out.mix = mix_scaled;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            active_right_gain <= audio_regs_pkg::RESET_RIGHT_ATTENUATION;
            active_mix_gain <= audio_regs_pkg::RESET_RIGHT_TO_LEFT_MIX;
            sample_out <= '0;
            sample_valid <= 1'b0;
        end else begin
            active_right_gain <= next_active_right_gain;
            active_mix_gain <= next_active_mix_gain;
            sample_out <= next_sample_out;
            sample_valid <= next_sample_valid;
        end
    end

    assign sample_o = sample_out;
    assign sample_valid_o = sample_valid;
    assign right_attenuation_o = active_right_gain;
    assign right_to_left_mix_o = active_mix_gain;

endmodule // right_volume_mix_pll441_regs

// >>> testbench.sv
// Self-checking bench for the right volume, mix and PLL register bank.
// Assumes the host model drives accesses and the bench drives samples.
`timescale 1ns/1ns
module testbench;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic soft_reset_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic signed [15:0] right_sample_i = 16'sh0000;
    audio_regs_pkg::reg_req_type reg_req;
    audio_regs_pkg::sample_pair_type sample_o;
    logic [7:0] rdata;
    logic rvalid;
    logic sample_valid_o;
    logic [7:0] att_o;
    logic [7:0] mix_o;
    logic [5:0] ratio_o;
    logic [15:0] frac_o;
    int fails = 0;
    int n_tests = 0;
    logic [7:0] ad [5] = '{8'h48, 8'h49, 8'h50, 8'h51, 8'h52};
    logic [7:0] rv [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv [5] = '{8'h0c, 8'h06, 8'hff, 8'h34, 8'h12};
    logic [7:0] bv [5] = '{8'h0c, 8'h06, 8'h1f, 8'h34, 8'h12};

    always #2 clk_sys_i = ~clk_sys_i;

    regs_host_model i_regs_host_model (.clk_sys_i(clk_sys_i),
        .rdata_i(rdata), .rvalid_i(rvalid), .req_o(reg_req));

    right_volume_mix_pll441_regs i_right_volume_mix_pll441_regs (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .soft_reset_i(soft_reset_i), .reg_req_i(reg_req),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .sample_valid_i(sample_valid_i), .right_sample_i(right_sample_i),
        .sample_o(sample_o), .sample_valid_o(sample_valid_o),
        .right_attenuation_o(att_o), .right_to_left_mix_o(mix_o),
        .pll_div_ratio_44k1_o(ratio_o), .pll_fraction_44k1_o(frac_o));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] vd;
        i_regs_host_model.read(a, vd);
        check({23'h0, vd}, {23'h0, 1'b1, e});
    endtask

    task automatic strobe(input logic signed [15:0] x);
        @(negedge clk_sys_i);
        sample_valid_i = 1'b1;
        right_sample_i = x;
        @(negedge clk_sys_i);
        sample_valid_i = 1'b0;
        check({31'h0, sample_valid_o}, 32'h1);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        close_out();
    end

    initial begin
        repeat (4) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(ad[i], rv[i]);
        rd_chk(8'h4a, 8'h00);
        check({att_o, mix_o, 10'h0, ratio_o}, 32'h00ff0001);
        for (int i = 0; i < 5; i++) i_regs_host_model.write(ad[i], wv[i]);
        i_regs_host_model.write(8'h4b, 8'h5a);
        rd_chk(8'h4b, 8'h00);
        for (int i = 0; i < 5; i++) rd_chk(ad[i], bv[i]);
        check({att_o, mix_o, frac_o}, 32'h00ff1234);
        check({26'h0, ratio_o}, 32'h20);
        strobe(16'sh4000);
        check(sample_o, {16'h0fff, 16'h1fff});
        check({att_o, mix_o}, 32'h0c06);
        i_regs_host_model.write(8'h48, 8'h01);
        strobe(16'sh4000);
        check(sample_o.right, 32'h390a);
        i_regs_host_model.write(8'h48, 8'hff);
        strobe(-16'sh8000);
        check(sample_o, {16'h0000, 16'hc000});
        @(negedge clk_sys_i);
        soft_reset_i = 1'b1;
        @(negedge clk_sys_i);
        soft_reset_i = 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(ad[i], rv[i]);
        check({att_o, 10'h0, ratio_o}, 32'hff0001);
        strobe(16'sh4000);
        check(sample_o, {16'h3fff, 16'h0000});
        for (int i = 0; i < 5; i++) i_regs_host_model.write(ad[i], wv[i]);
        @(negedge clk_sys_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(ad[i], rv[i]);
        check({att_o, mix_o, frac_o}, 32'h00ff0000);
        check({26'h0, ratio_o}, 32'h1);
        close_out();
    end
endmodule // testbench
